/* File: inc/vector_select_pkg.sv */
// Package with constants, source codes and carriers for vector address selection.
package vector_select_pkg;

  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned IRQ_W        = 6;
  localparam int unsigned VEC_W        = 7;
  localparam int unsigned TRAP_W       = 3;
  localparam int unsigned CTL_W        = 16;
  localparam int unsigned ALT_SEL_BIT  = 15;

  localparam logic [ADDR_W-1:0] RESET_ADDR   = 24'h000000;
  localparam logic [ADDR_W-1:0] TABLE_BASE   = 24'h000004;
  localparam logic [ADDR_W-1:0] IRQ_BASE     = 24'h000014;
  localparam logic [ADDR_W-1:0] ALT_OFFSET   = 24'h000100;
  localparam logic [VEC_W-1:0]  IRQ_VEC_OFS  = 7'h08;
  localparam logic [IRQ_W-1:0]  IRQ_LAST     = 6'h2d;
  localparam int unsigned       SLOT_SHIFT   = 1;

  // Source assignment per request number.
  typedef enum logic [5:0] {
    SRC_EXT_IRQ_ZERO       = 6'h00,
    SRC_INPUT_CAPTURE_ONE  = 6'h01,
    SRC_OUTPUT_COMPARE_ONE = 6'h02,
    SRC_TIMER_ONE          = 6'h03,
    SRC_DMA_CHANNEL_ZERO   = 6'h04,
    SRC_INPUT_CAPTURE_TWO  = 6'h05,
    SRC_OUTPUT_COMPARE_TWO = 6'h06,
    SRC_TIMER_TWO          = 6'h07,
    SRC_TIMER_THREE        = 6'h08,
    SRC_SPI_ONE_ERROR      = 6'h09,
    SRC_SPI_ONE_DONE       = 6'h0a,
    SRC_UART_ONE_RECEIVE   = 6'h0b,
    SRC_UART_ONE_TRANSMIT  = 6'h0c,
    SRC_CONVERTER_ONE_DONE = 6'h0d,
    SRC_DMA_CHANNEL_ONE    = 6'h0e,
    SRC_RESERVED_15        = 6'h0f,
    SRC_I2C_ONE_SLAVE      = 6'h10,
    SRC_I2C_ONE_MASTER     = 6'h11,
    SRC_RESERVED_18        = 6'h12,
    SRC_CHANGE_NOTIFY      = 6'h13,
    SRC_EXT_IRQ_ONE        = 6'h14,
    SRC_CONVERTER_TWO_DONE = 6'h15,
    SRC_INPUT_CAPTURE_7    = 6'h16,
    SRC_INPUT_CAPTURE_8    = 6'h17,
    SRC_DMA_CHANNEL_TWO    = 6'h18,
    SRC_OUTPUT_COMPARE_3   = 6'h19,
    SRC_OUTPUT_COMPARE_4   = 6'h1a,
    SRC_TIMER_FOUR         = 6'h1b,
    SRC_TIMER_FIVE         = 6'h1c,
    SRC_EXT_IRQ_TWO        = 6'h1d,
    SRC_UART_TWO_RECEIVE   = 6'h1e,
    SRC_UART_TWO_TRANSMIT  = 6'h1f,
    SRC_SPI_TWO_ERROR      = 6'h20,
    SRC_SPI_DONE_B         = 6'h21,
    SRC_CAN_ONE_RX_READY   = 6'h22,
    SRC_CAN_ONE_EVENT      = 6'h23,
    SRC_DMA_CHANNEL_THREE  = 6'h24,
    SRC_INPUT_CAPTURE_3    = 6'h25,
    SRC_INPUT_CAPTURE_4    = 6'h26,
    SRC_INPUT_CAPTURE_5    = 6'h27,
    SRC_INPUT_CAPTURE_6    = 6'h28,
    SRC_OUTPUT_COMPARE_5   = 6'h29,
    SRC_OUTPUT_COMPARE_6   = 6'h2a,
    SRC_OUTPUT_COMPARE_7   = 6'h2b,
    SRC_OUTPUT_COMPARE_8   = 6'h2c,
    SRC_RESERVED_45        = 6'h2d
  } source_e;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RESET = 2'b01
  } state_e;

  // Request from the arbiter: a trap or an interrupt request.
  typedef struct packed {
    logic              valid;
    logic              is_trap;
    logic [TRAP_W-1:0] trap_num;
    logic [IRQ_W-1:0]  irq_num;
  } vec_req_s;

  // Answer to the core.
  typedef struct packed {
    logic              valid;
    logic              reserved;
    logic [VEC_W-1:0]  vec_num;
    logic [ADDR_W-1:0] addr;
  } vec_ans_s;

endpackage : vector_select_pkg

/* File: verilog/vector_slot_addr.sv */
// Combinational vector number and slot address for one table.
`timescale 1ns/1ns
module vector_slot_addr
  import vector_select_pkg::*;
(
  input  wire logic                           is_trap,
  input  wire logic [vector_select_pkg::TRAP_W-1:0] trap_num,
  input  wire logic [vector_select_pkg::IRQ_W-1:0]  irq_num,
  output logic      [vector_select_pkg::VEC_W-1:0]  vec_num,
  output logic      [vector_select_pkg::ADDR_W-1:0] addr
);

  logic [VEC_W-1:0] num;

  always_comb begin
    if (is_trap) begin
      num = {{(VEC_W-TRAP_W){1'b0}}, trap_num};
    end else begin
      num = VEC_W'({1'b0, irq_num} + IRQ_VEC_OFS); // RULE_03
    end
    vec_num = num;
    // Traps sit in the first eight slots, so irq n lands at base plus 2n plus 16.
    addr = ADDR_W'(TABLE_BASE + (ADDR_W'(num) << SLOT_SHIFT)); // RULE_16
  end

endmodule : vector_slot_addr

/* File: verilog/interrupt_vector_table_select.sv */
// Vector address generation with default/alternate table select and reset.
// Contract
// RULE_01 - Select bit set makes every vector fetch use the alternate table.
// RULE_02 - Alternate address equals default address plus 0x100, same layout.
// RULE_03 - Request n maps to vector n plus 8 at 0x14 plus 2n.
// RULE_04 - Reset clears state and forces the program counter to zero.
// RULE_05 - Reset is no exception; no vector fetch happens for it.
// RULE_06 - Requests 0-7: ext0, cap1, cmp1, t1, dma 0, cap2, cmp2, t2.
// RULE_07 - Requests 8-14: t3, spi1 err/done, uart1 rx/tx, conv1, dma1.
// RULE_08 - Requests 16-22: i2c1 slv/mst, reserved, cn, ext1, conv2, cap7.
// RULE_09 - Requests 23-31: cap8, dma2, cmp3, cmp4, t4, t5, ext2, uart2.
// RULE_10 - Requests 32 to 45: spi2, can1, dma3, ic3-6, oc5-8, reserved.
// RULE_11 - Software fills an unneeded alternate table like the default one.
// RULE_12 - Software fills unused slots with a software-reset handler address.
// RULE_13 - Software places a jump to start-up code at the reset address.
// RULE_14 - Each slot holds a 24-bit handler address loaded into the counter.
// RULE_15 - Lower vector addresses carry higher natural priority.
// RULE_16 - Default table starts at 0x000004; traps take the first eight slots.
// RULE_17 - The select bit is sampled when each vector address is formed.
`timescale 1ns/1ns
module interrupt_vector_table_select
  import vector_select_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic [vector_select_pkg::CTL_W-1:0] interrupt_control_two,
  input  wire vector_select_pkg::vec_req_s         req,
  input  wire logic [vector_select_pkg::ADDR_W-1:0] handler_addr,
  output logic                                     pc_load,
  output logic      [vector_select_pkg::ADDR_W-1:0] pc_value,
  output vector_select_pkg::vec_ans_s              ans,
  output logic      [vector_select_pkg::IRQ_W-1:0] priority_rank,
  output logic                                     alt_table_select
);
  import vector_select_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    state_e            state;
    logic              pend;
    logic              pc_load;
    logic [ADDR_W-1:0] pc_value;
    vec_ans_s          ans;
    logic [IRQ_W-1:0]  rank;
    logic              alt;
  } regs_s;

  regs_s r_r;
  regs_s r_nxt;

  logic [VEC_W-1:0]  dflt_num;
  logic [ADDR_W-1:0] dflt_addr;

  vector_slot_addr u_slot (
    .is_trap  (req.is_trap),
    .trap_num (req.trap_num),
    .irq_num  (req.irq_num),
    .vec_num  (dflt_num),
    .addr     (dflt_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic sel;
    logic in_table;
    sel = interrupt_control_two[ALT_SEL_BIT]; // RULE_17
    in_table = 1'b0;
    r_nxt = r_r;
    r_nxt.pc_load = 1'b0;
    r_nxt.ans.valid = 1'b0;
    r_nxt.alt = sel;
    case (r_r.state)
      ST_RESET: begin
        // Reset vectors straight to zero; the table is never consulted.
        r_nxt.pc_load  = 1'b1; // RULE_05
        r_nxt.pc_value = RESET_ADDR; // RULE_04
        r_nxt.state    = ST_RUN;
      end
      ST_RUN: begin
        if (r_r.pend) begin
          // The slot fetched last cycle now holds the 24-bit handler address.
          r_nxt.pc_load  = 1'b1;
          r_nxt.pc_value = handler_addr; // RULE_14
          r_nxt.pend     = 1'b0;
        end
        if (req.valid) begin
          r_nxt.ans.valid    = 1'b1;
          r_nxt.ans.vec_num  = dflt_num;
          // The flag comes from the source names listed below, so a slot added to
          // the table is flagged reserved until it is also listed here.
          if (req.is_trap) begin
            in_table = 1'b1; // RULE_16
          end else begin
            case (req.irq_num)
              // Requests 0 to 7.
              SRC_EXT_IRQ_ZERO,
              SRC_INPUT_CAPTURE_ONE,
              SRC_OUTPUT_COMPARE_ONE,
              SRC_TIMER_ONE,
              SRC_DMA_CHANNEL_ZERO,
              SRC_INPUT_CAPTURE_TWO,
              SRC_OUTPUT_COMPARE_TWO,
              SRC_TIMER_TWO: begin
                in_table = 1'b1; // RULE_06
              end

              // Requests 8 to 15.
              SRC_TIMER_THREE,
              SRC_SPI_ONE_ERROR,
              SRC_SPI_ONE_DONE,
              SRC_UART_ONE_RECEIVE,
              SRC_UART_ONE_TRANSMIT,
              SRC_CONVERTER_ONE_DONE,
              SRC_DMA_CHANNEL_ONE,
              SRC_RESERVED_15: begin
                in_table = 1'b1; // RULE_07
              end

              // Requests 16 to 22.
              SRC_I2C_ONE_SLAVE,
              SRC_I2C_ONE_MASTER,
              SRC_RESERVED_18,
              SRC_CHANGE_NOTIFY,
              SRC_EXT_IRQ_ONE,
              SRC_CONVERTER_TWO_DONE,
              SRC_INPUT_CAPTURE_7: begin
                in_table = 1'b1; // RULE_08
              end

              // Requests 23 to 31.
              SRC_INPUT_CAPTURE_8,
              SRC_DMA_CHANNEL_TWO,
              SRC_OUTPUT_COMPARE_3,
              SRC_OUTPUT_COMPARE_4,
              SRC_TIMER_FOUR,
              SRC_TIMER_FIVE,
              SRC_EXT_IRQ_TWO,
              SRC_UART_TWO_RECEIVE,
              SRC_UART_TWO_TRANSMIT: begin
                in_table = 1'b1; // RULE_09
              end

              // Requests 32 to 45.
              SRC_SPI_TWO_ERROR,
              SRC_SPI_DONE_B,
              SRC_CAN_ONE_RX_READY,
              SRC_CAN_ONE_EVENT,
              SRC_DMA_CHANNEL_THREE,
              SRC_INPUT_CAPTURE_3,
              SRC_INPUT_CAPTURE_4,
              SRC_INPUT_CAPTURE_5,
              SRC_INPUT_CAPTURE_6,
              SRC_OUTPUT_COMPARE_5,
              SRC_OUTPUT_COMPARE_6,
              SRC_OUTPUT_COMPARE_7,
              SRC_OUTPUT_COMPARE_8,
              SRC_RESERVED_45: begin
                in_table = 1'b1; // RULE_10
              end

              // Numbers past the table are flagged, never remapped.
              default: begin
                in_table = 1'b0;
              end
            endcase
          end
          r_nxt.ans.reserved = !in_table;
          // Both tables share one layout, offset by a fixed distance.
          r_nxt.ans.addr = sel ? ADDR_W'(dflt_addr + ALT_OFFSET)
                               : dflt_addr; // RULE_01 RULE_02
          // Rank equals the slot index: smaller wins among equal levels.
          r_nxt.rank     = IRQ_W'(dflt_num); // RULE_15
          r_nxt.pend     = 1'b1;
        end
      end
      default: begin
        r_nxt.state = ST_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_r          <= '0; // RULE_04
      r_r.state    <= ST_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign pc_load          = r_r.pc_load;
  assign pc_value         = r_r.pc_value;
  assign ans              = r_r.ans;
  assign priority_rank    = r_r.rank;
  assign alt_table_select = r_r.alt;

endmodule : interrupt_vector_table_select

/* File: verification/vector_select_asserts.sv */
// Concurrent checks on the vector select ports.
`timescale 1ns/1ns
module vector_select_asserts
  import vector_select_pkg::*;
(
  input wire logic                                 clk,
  input wire logic                                 arst_n,
  input wire logic [vector_select_pkg::CTL_W-1:0]  interrupt_control_two,
  input wire vector_select_pkg::vec_req_s          req,
  input wire logic [vector_select_pkg::ADDR_W-1:0] handler_addr,
  input wire logic                                 pc_load,
  input wire logic [vector_select_pkg::ADDR_W-1:0] pc_value,
  input wire vector_select_pkg::vec_ans_s          ans,
  input wire logic [vector_select_pkg::IRQ_W-1:0]  priority_rank,
  input wire logic                                 alt_table_select
);
  logic up_r;
  wire  take = req.valid && up_r;
  // Low on the first edge after release, where a request is ignored.
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) up_r <= 1'b0;
    else up_r <= 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_fetch;
    ans.valid ##1 pc_load;
  endsequence
  sequence s_exit;
    !up_r ##1 (pc_load && pc_value == RESET_ADDR && !ans.valid);
  endsequence
  a_ans_after_req: assert property (take |=> ans.valid)
    else $error("no answer after a request");
  a_no_stray_ans: assert property (ans.valid |-> $past(take))
    else $error("answer without a request");
  a_irq_vec_num: assert property (take && !req.is_trap |=>
    ans.vec_num == $past(req.irq_num) + IRQ_VEC_OFS)
    else $error("wrong interrupt vector number");
  a_trap_vec_num: assert property (take && req.is_trap |=>
    ans.vec_num == $past(req.trap_num)) else $error("wrong trap vector");
  a_addr_layout: assert property (ans.valid |->
    ans.addr == TABLE_BASE + {ans.vec_num, 1'b0} +
    ($past(interrupt_control_two[ALT_SEL_BIT]) ? ALT_OFFSET : '0))
    else $error("wrong vector address");
  a_pc_load_fetch: assert property (ans.valid |-> s_fetch
    ##0 pc_value == $past(handler_addr)) else $error("handler not loaded");
  a_reset_entry: assert property (!up_r |-> s_exit)
    else $error("reset entry not at zero");
  a_alt_sel_copy: assert property ($past(arst_n) |->
    alt_table_select == $past(interrupt_control_two[ALT_SEL_BIT]))
    else $error("select copy wrong");
  a_reserved_flag: assert property (take && !req.is_trap |=>
    ans.reserved == ($past(req.irq_num) > IRQ_LAST))
    else $error("wrong reserved flag");
  a_rank_by_addr: assert property (ans.valid |->
    {priority_rank, 1'b0} == 7'(ans.addr[7:0] - 8'h04))
    else $error("rank not slot index");
endmodule : vector_select_asserts

/* File: verification/vector_fetch_model.sv */
// Program memory model answering vector fetches with handler addresses.
`timescale 1ns/1ns
module vector_fetch_model
  import vector_select_pkg::*;
(
  input wire vector_select_pkg::vec_ans_s   ans,
  output logic [vector_select_pkg::ADDR_W-1:0] handler_addr
);
  logic [23:0] h;
  // Outside a fetch the bus shows the inverse, so a late sample is caught.
  always_comb begin
    h = 24'h010000 | (ans.addr & 24'h00feff);
    if (ans.vec_num inside {7'h17, 7'h1a, 7'h35}) h = 24'h0002fe;
    // The reset word is the start-up jump, never a handler address.
    if (ans.addr < 24'h000004) h = 24'hffffff;
    handler_addr = ans.valid ? h : ~h;
  end
endmodule : vector_fetch_model

/* File: verification/tb_interrupt_vector_table_select.sv */
// Self-checking bench for vector address selection.
`timescale 1ns/1ns
module tb_interrupt_vector_table_select;
  import vector_select_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, run = 1'b0, pc_pend = 1'b0;
  logic [15:0] interrupt_control_two = 16'h0000;
  vec_req_s    req = '0;
  logic [23:0] handler_addr, pc_value, pc_exp;
  logic        pc_load, alt_table_select;
  logic [5:0]  priority_rank;
  vec_ans_s    ans, e, q[$];
  int          err_total = 0, comparisons = 0, i;
  initial forever #10 clk = ~clk;
  interrupt_vector_table_select dut (.clk(clk), .arst_n(arst_n),
    .interrupt_control_two(interrupt_control_two), .req(req),
    .handler_addr(handler_addr), .pc_load(pc_load), .pc_value(pc_value),
    .ans(ans), .priority_rank(priority_rank),
    .alt_table_select(alt_table_select));
  vector_fetch_model mem (.ans(ans), .handler_addr(handler_addr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [23:0] hnd(vec_ans_s x);
    if (x.vec_num inside {7'h17, 7'h1a, 7'h35}) return 24'h0002fe;
    return 24'h010000 | (x.addr & 24'h00feff);
  endfunction : hnd
  task automatic send(logic trap, logic [5:0] n, logic alt);
    vec_ans_s x;
    x.vec_num = trap ? {4'h0, n[2:0]} : {1'b0, n} + 7'h08;
    x.addr = 24'h000004 + {x.vec_num, 1'b0} + (alt ? 24'h000100 : 24'h0);
    x.valid = 1'b1;
    x.reserved = !trap && (n > 6'h2d);
    q.push_back(x);
    req <= '{1'b1, trap, n[2:0], n};
    interrupt_control_two <= {alt, 15'($urandom)};
    @(posedge clk);
  endtask : send
  task automatic idle;
    req <= '0;
    @(posedge clk);
  endtask : idle
  task automatic do_reset;
    run = 1'b0;
    arst_n <= 1'b0;
    req <= '0;
    q.delete();
    repeat (20) @(posedge clk);
    chk("reset pc", {pc_load, pc_value, alt_table_select}, 33'h0);
    chk("reset ans", ans, 33'h0);
    chk("reset rank", 33'(priority_rank), 33'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    pc_pend = 1'b1;
    pc_exp = 24'h000000;
    run = 1'b1;
  endtask : do_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
    if (run) begin
      chk("pc_load", pc_load, pc_pend);
      if (pc_pend) chk("pc_value", pc_value, pc_exp);
      pc_pend = 1'b0;
      if (ans.valid !== 1'b0) begin
        if (q.size() == 0) chk("stray ans", 1'b1, 1'b0);
        else begin
          e = q.pop_front();
          chk("ans", ans, e);
          chk("rank", 33'(priority_rank), 33'(e.vec_num[5:0]));
          pc_pend = 1'b1;
          pc_exp = hnd(e);
        end
      end
    end
  initial begin
    i = $urandom(93172);
    do_reset;
    for (i = 0; i < 92; i++)
      send(1'b0, 6'(i >> 1), i[0]);
    for (i = 0; i < 16; i++)
      send(1'b1, 6'(i >> 1), i[0]);
    for (i = 46; i < 56; i++)
      send(1'b0, 6'(i), i[0]);
    repeat (400) begin
      send(1'($urandom), 6'($urandom % 56), 1'($urandom));
      if ($urandom % 3 == 0) idle;
    end
    send(1'b0, 6'h05, 1'b1);
    do_reset;
    send(1'b0, SRC_TIMER_ONE, 1'b0);
    repeat (3) idle;
    chk("pending", 33'(q.size()), 33'h0);
    tally_and_finish;
  end
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule : tb_interrupt_vector_table_select
bind interrupt_vector_table_select vector_select_asserts chk_i (.clk(clk),
  .arst_n(arst_n), .interrupt_control_two(interrupt_control_two),
  .req(req), .handler_addr(handler_addr), .pc_load(pc_load),
  .pc_value(pc_value), .ans(ans), .priority_rank(priority_rank),
  .alt_table_select(alt_table_select));
